// >>> core/qd_quad_decoder.sv
// quadrature decoder: pin sync, noise filters, position counter, timer, axi4-lite slave
// assumes one 50 mhz clock; sleep and idle levels come from logic on that clock
//
// The address map and the AXI4-Lite slave port were decided locally.
`default_nettype none
`include "qd_params.svh"

module qd_quad_decoder
    import qd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // encoder pins
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    // power state
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    // status outputs
    output logic count_direction,
    output logic module_irq_flag,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    //--------------------------------------------------
    // functions
    //--------------------------------------------------

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] w,
                                          input logic [3:0] s);
        logic [15:0] r;
        r = o;
        if (s[0])
            r[7:0] = w[7:0];
        if (s[1])
            r[15:8] = w[15:8];
        return r;
    endfunction

    // control register word
    function automatic logic [15:0] ctl_word(input qd_state_t s);
        logic [15:0] r;
        r = 16'h0000;
        r[`QD_B_ERR] = s.err;
        r[`QD_B_IDLE] = s.idle_stop;
        r[`QD_B_DIR] = s.dir;
        r[`QD_F_MODE] = s.mode;
        r[`QD_B_IDXRST] = s.idx_rst_en;
        r[`QD_B_DSRC] = s.dsrc;
        return r;
    endfunction

    // filter control register word
    function automatic logic [15:0] flt_word(input qd_state_t s);
        logic [15:0] r;
        r = 16'h0000;
        r[`QD_F_MATCH] = s.match;
        r[`QD_B_ERRDIS] = s.err_dis;
        r[`QD_B_FEN] = s.flt_en;
        r[`QD_F_DIV] = s.fdiv;
        return r;
    endfunction

    //--------------------------------------------------
    // reset release
    //--------------------------------------------------

    logic [1:0] rst_s_q;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s_q <= 2'h0;
        end
        else
        begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end

    assign rst_n = rst_s_q[1];

    //--------------------------------------------------
    // derived terms
    //--------------------------------------------------

    qd_state_t q;
    qd_state_t d;
    logic run, tick, enc, x4, maxrst, timer;
    logic a, b, x, ea, eb, up, cnt_ev, idx_ev, idx_ok;
    logic t_ev, t_up, enc_err, wrap_ev, tmr_ev, do_wr, pos_wr;
    logic [2:0] agree, feq, sel;
    logic [6:0] div_lim;
    logic [7:0] wa, ra;
    logic [15:0] nxt, cw, fw;

    // halted in sleep, and in idle when stop bit set
    assign run = ~cpu_sleep & ~(cpu_idle & q.idle_stop);
    assign div_lim = (7'h01 << q.fdiv) - 7'h01;
    // at or past the limit, so a smaller divide takes effect at once
    assign tick = (q.div >= div_lim);
    assign agree = ~(q.s2 ^ q.s3);
    assign feq = ~(q.h1 ^ q.v) & ~(q.h2 ^ q.v);

    // filtered or synchronised channels
    assign sel = q.flt_en ? q.fo : q.v;
    assign a = sel[0];
    assign b = sel[1];
    assign x = sel[2];
    assign ea = a ^ q.prev[0];
    assign eb = b ^ q.prev[1];

    // mode decode
    assign enc = q.mode[`QD_M_ENC];
    assign x4 = q.mode[`QD_M_X4];
    assign maxrst = q.mode[`QD_M_MAXRST];
    assign timer = (q.mode == `QD_M_TIMER);

    // quadrature direction and count pulse
    assign up = ea ? (a ^ b) : ~(a ^ b);
    assign cnt_ev = run & enc & (x4 ? (ea ^ eb) : (ea & ~eb));
    assign idx_ok = x4 ? (b == q.match[1] && a == q.match[0])
                       : ((q.match[1] ? b : a) == q.match[0]);
    assign idx_ev = run & enc & ~maxrst & x & ~q.prev[2] & idx_ok;
    assign nxt = up ? q.pos + 16'h0001 : q.pos - 16'h0001;

    // count error only in index modes
    assign enc_err = cnt_ev & ~maxrst & (up ? (nxt == q.maxc + 16'h0001)
                                            : (nxt == `QD_MAX_RST));
    assign wrap_ev = cnt_ev & maxrst & (up ? (q.pos == q.maxc) : (q.pos == 16'h0000));

    // timer steps on synchronised rising edge of phase a
    assign t_ev = run & timer & a & ~q.prev[0];
    assign t_up = q.dsrc ? b : q.dir;
    assign tmr_ev = t_ev & (t_up ? (q.pos == q.maxc) : (q.pos == 16'h0000));

    // bus write decode
    assign do_wr = ~q.aw_rdy & ~q.w_rdy & ~q.bvalid;
    assign wa = {q.aw_addr[7:2], 2'h0};
    assign ra = {s_axi_araddr[7:2], 2'h0};
    assign pos_wr = do_wr && (wa == `QD_OFF_POS);
    assign cw = merge(ctl_word(q), q.w_data, q.w_strb);
    assign fw = merge(flt_word(q), q.w_data, q.w_strb);

    //--------------------------------------------------
    // next state
    //--------------------------------------------------

    always_comb
    begin
        d = q;
        // three-stage pin synchroniser
        d.s1 = {index_input, phase_b_input, phase_a_input};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.v = (agree & q.s3) | (~agree & q.v);
        // filter clock and three-sample filter
        if (run)
        begin
            d.div = tick ? 7'h00 : q.div + 7'h01;
            if (tick)
            begin
                d.h1 = q.v;
                d.h2 = q.h1;
                d.fo = (feq & q.v) | (~feq & q.fo);
            end
            d.prev = sel;
        end
        // axi write channels
        if (s_axi_awvalid && q.aw_rdy)
        begin
            d.aw_addr = s_axi_awaddr;
            d.aw_rdy = 1'b0;
        end
        if (s_axi_wvalid && q.w_rdy)
        begin
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
            d.w_rdy = 1'b0;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
            d.aw_rdy = 1'b1;
            d.w_rdy = 1'b1;
        end
        // register write, mode change leaves count alone
        if (do_wr)
        begin
            d.bvalid = 1'b1;
            d.bresp = `QD_RESP_OK;
            if (wa == `QD_OFF_CTRL)
            begin
                d.err = cw[`QD_B_ERR];
                d.idle_stop = cw[`QD_B_IDLE];
                d.mode = cw[`QD_F_MODE];
                d.idx_rst_en = cw[`QD_B_IDXRST];
                d.dsrc = cw[`QD_B_DSRC];
                if (!enc)
                begin
                    d.dir = cw[`QD_B_DIR];
                end
            end
            else if (wa == `QD_OFF_FILT)
            begin
                d.match = fw[`QD_F_MATCH];
                d.err_dis = fw[`QD_B_ERRDIS];
                d.flt_en = fw[`QD_B_FEN];
                d.fdiv = fw[`QD_F_DIV];
            end
            else if (wa == `QD_OFF_POS)
                d.pos = q.pos;
            else if (wa == `QD_OFF_MAX)
                d.maxc = merge(q.maxc, q.w_data, q.w_strb);
            else if (wa == `QD_OFF_STAT)
            begin
                if (q.w_strb[0] && q.w_data[`QD_B_IRQ])
                    d.irq = 1'b0;
            end
            else
                d.bresp = `QD_RESP_ERR;
        end
        // encoder counting, index clear has priority
        if (idx_ev && q.idx_rst_en)
            d.pos = 16'h0000;
        else if (cnt_ev)
            d.pos = wrap_ev ? (up ? 16'h0000 : q.maxc) : nxt;
        if (cnt_ev)
            d.dir = up;
        // timer counting against the period, pin direction mirrored
        if (t_ev)
            d.pos = tmr_ev ? (t_up ? 16'h0000 : q.maxc)
                           : (t_up ? q.pos + 16'h0001 : q.pos - 16'h0001);
        if (run && timer && q.dsrc)
            d.dir = b;
        // sticky flags, set beats clear
        if (enc_err)
            d.err = 1'b1;
        if (wrap_ev || idx_ev || (enc_err && !q.err_dis) || tmr_ev)
            d.irq = 1'b1;
        // software write of the count wins over counting
        if (pos_wr)
            d.pos = merge(q.pos, q.w_data, q.w_strb);
        // axi read channel
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
            d.ar_rdy = 1'b1;
        end
        if (s_axi_arvalid && q.ar_rdy)
        begin
            d.ar_rdy = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = `QD_RESP_OK;
            d.rdata = 32'h00000000;
            if (ra == `QD_OFF_CTRL)
                d.rdata[15:0] = ctl_word(q);
            else if (ra == `QD_OFF_FILT)
                d.rdata[15:0] = flt_word(q);
            else if (ra == `QD_OFF_POS)
                d.rdata[15:0] = q.pos;
            else if (ra == `QD_OFF_MAX)
                d.rdata[15:0] = q.maxc;
            else if (ra == `QD_OFF_STAT)
                d.rdata[`QD_B_IRQ] = q.irq;
            else
                d.rresp = `QD_RESP_ERR;
        end
    end

    // state register, filters off at reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.maxc <= `QD_MAX_RST;
            q.aw_rdy <= 1'b1;
            q.w_rdy <= 1'b1;
            q.ar_rdy <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    //--------------------------------------------------
    // outputs
    //--------------------------------------------------

    assign count_direction = q.dir;
    assign module_irq_flag = q.irq;
    assign s_axi_awready = q.aw_rdy;
    assign s_axi_wready = q.w_rdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.ar_rdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    //--------------------------------------------------
    // checks
    //--------------------------------------------------

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_err_sticky: assert property (q.err && !(do_wr && wa == `QD_OFF_CTRL) |=> q.err)
        else $error("count error flag dropped");
    a_err_sets: assert property (enc_err |=> q.err)
        else $error("count error not flagged");
    a_err_masked: assert property (enc_err && q.err_dis && !q.irq && !idx_ev && !wrap_ev
                                   |=> !q.irq)
        else $error("masked count error raised flag");
    a_x2_b_only: assert property (enc && !x4 && run && eb && !ea && !idx_ev && !pos_wr
                                  |=> $stable(q.pos))
        else $error("x2 counted a b edge");
    a_x4_step: assert property (cnt_ev && x4 && !maxrst && up && !idx_ev && !pos_wr
                                |=> q.pos == $past(q.pos) + 16'h0001)
        else $error("x4 up step wrong");
    a_idx_clear: assert property (idx_ev && q.idx_rst_en && !pos_wr |=> q.pos == 16'h0000)
        else $error("index did not clear count");
    a_idx_irq: assert property (idx_ev |=> q.irq)
        else $error("index did not raise flag");
    a_flt_tick: assert property ($changed(q.fo) |-> $past(tick) && $past(run))
        else $error("filter moved off its clock");
    a_tmr_period: assert property (t_ev && t_up && q.pos == q.maxc && !pos_wr
                                   |=> q.pos == 16'h0000 && q.irq)
        else $error("timer period match missed");
    a_halt_sleep: assert property (cpu_sleep && !pos_wr ##1 cpu_sleep |-> $stable(q.pos))
        else $error("count moved in sleep");

    c_idx_clear: cover property (idx_ev && q.idx_rst_en);
    c_count_err: cover property (enc_err ##1 q.err);
    c_tmr_match: cover property (tmr_ev);
    c_x4_down: cover property (cnt_ev && x4 && !up);

endmodule // qd_quad_decoder
`default_nettype wire

// >>> core/qd_params.svh
// named offsets, field positions, reset values and codes of the quadrature decoder
// assumes inclusion by bare name from design files
`ifndef QD_PARAMS_SVH
`define QD_PARAMS_SVH
// register byte offsets
`define QD_OFF_CTRL 8'h00
`define QD_OFF_FILT 8'h04
`define QD_OFF_POS 8'h08
`define QD_OFF_MAX 8'h0C
`define QD_OFF_STAT 8'h10
// control register fields
`define QD_B_ERR 15
`define QD_B_IDLE 13
`define QD_B_DIR 11
`define QD_F_MODE 10:8
`define QD_B_IDXRST 2
`define QD_B_DSRC 0
// filter control register fields
`define QD_F_MATCH 10:9
`define QD_B_ERRDIS 8
`define QD_B_FEN 7
`define QD_F_DIV 6:4
// status register fields
`define QD_B_IRQ 0
// mode field bits and codes
`define QD_M_ENC 2
`define QD_M_X4 1
`define QD_M_MAXRST 0
`define QD_M_TIMER 3'h1
// reset values and answers
`define QD_MAX_RST 16'hFFFF
`define QD_RESP_OK 2'h0
`define QD_RESP_ERR 2'h2
`endif

// >>> core/qd_pkg.sv
// types of the quadrature decoder: the complete state record
// assumes qd_params.svh for the constants
`default_nettype none
package qd_pkg;
    // whole state of the decoder, channels packed as {index, b, a}
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] v;
        logic [2:0] h1;
        logic [2:0] h2;
        logic [2:0] fo;
        logic [2:0] prev;
        logic [6:0] div;
        logic err;
        logic idle_stop;
        logic dir;
        logic [2:0] mode;
        logic idx_rst_en;
        logic dsrc;
        logic [1:0] match;
        logic err_dis;
        logic flt_en;
        logic [2:0] fdiv;
        logic [15:0] pos;
        logic [15:0] maxc;
        logic irq;
        logic aw_rdy;
        logic w_rdy;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } qd_state_t;
endpackage : qd_pkg
`default_nettype wire

// >>> verification/qd_encoder_model.sv
// incremental encoder model: two quadrature phases and an index pulse
// assumes the bench calls its tasks from the mclk domain, one at a time
`default_nettype none
module qd_encoder_model (
    // clock
    input wire logic mclk,
    // encoder pins
    output logic phase_a,
    output logic phase_b,
    output logic index
);
    timeunit 1ns;
    timeprecision 1ps;

    int hold = 12;
    logic [1:0] ph = 2'h0;
    logic a_flip = 1'h0;
    logic idx_q = 1'h0;

    // forward cycle of the phases: 00, 10, 11, 01, so a leads b
    always_comb phase_a = ((ph == 2'h1) || (ph == 2'h2)) ^ a_flip;
    always_comb phase_b = ph[1];
    always_comb index = idx_q;

    // one edge per step, each level held for hold+1 cycles
    task automatic step(input logic fwd, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            ph <= fwd ? ph + 2'h1 : ph - 2'h1;
            repeat (hold) @(posedge mclk);
        end
    endtask

    // moves forward until both phases are low
    task automatic align();
        while (ph != 2'h0)
            step(1'h1, 1);
    endtask

    // index pulse while both phases are low
    task automatic pulse_index();
        @(posedge mclk);
        idx_q <= 1'h1;
        repeat (hold) @(posedge mclk);
        idx_q <= 1'h0;
        repeat (hold) @(posedge mclk);
    endtask

    // phase a inverted for n cycles, also serves as a timer tick
    task automatic glitch_a(input int n);
        @(posedge mclk);
        a_flip <= 1'h1;
        repeat (n) @(posedge mclk);
        a_flip <= 1'h0;
        repeat (hold) @(posedge mclk);
    endtask
endmodule // qd_encoder_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench of the quadrature decoder over its axi4-lite port
// assumes the encoder model drives the pins and qd_params.svh gives offsets
`default_nettype none
`include "qd_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [31:0] exp;
        logic [1:0] resp;
    } qd_row_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] filt;
        logic clr;
        logic flag;
    } qd_idx_t;

    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic cpu_sleep = 1'h0;
    logic cpu_idle = 1'h0;
    logic pa, pb, pi, dir, irq;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0;
    int checks = 0;

    qd_row_t rows [12] = '{
        '{1'h0, `QD_OFF_CTRL, 32'h0, 4'h0, 32'h0, `QD_RESP_OK},
        '{1'h0, `QD_OFF_FILT, 32'h0, 4'h0, 32'h0, `QD_RESP_OK},
        '{1'h0, `QD_OFF_POS, 32'h0, 4'h0, 32'h0, `QD_RESP_OK},
        '{1'h0, `QD_OFF_MAX, 32'h0, 4'h0, {16'h0, `QD_MAX_RST}, `QD_RESP_OK},
        '{1'h0, `QD_OFF_STAT, 32'h0, 4'h0, 32'h0, `QD_RESP_OK},
        '{1'h0, 8'h14, 32'h0, 4'h0, 32'h0, `QD_RESP_ERR},
        '{1'h1, 8'h14, 32'h5, 4'hF, 32'h0, `QD_RESP_ERR},
        '{1'h1, 8'hE6, 32'hFFFF0000, 4'hC, 32'h0, `QD_RESP_ERR},
        '{1'h1, `QD_OFF_MAX, 32'h1234, 4'hF, 32'h1234, `QD_RESP_OK},
        '{1'h1, 8'h0F, 32'h5678, 4'h1, 32'h1278, `QD_RESP_OK},
        '{1'h1, `QD_OFF_POS, 32'h1ABCD, 4'h2, 32'hAB00, `QD_RESP_OK},
        '{1'h1, `QD_OFF_CTRL, 32'hFFFF0800, 4'hF, 32'h0800, `QD_RESP_OK}};
    qd_idx_t irows [5] = '{
        '{32'h0604, 32'h0000, 1'h1, 1'h1},
        '{32'h0604, 32'h0600, 1'h0, 1'h0},
        '{32'h0600, 32'h0000, 1'h0, 1'h1},
        '{32'h0404, 32'h0400, 1'h1, 1'h1},
        '{32'h0404, 32'h0200, 1'h0, 1'h0}};

    // 50 mhz clock
    initial forever #10 mclk = ~mclk;

    qd_encoder_model enc (.mclk(mclk), .phase_a(pa), .phase_b(pb), .index(pi));

    qd_quad_decoder DUT (
        .mclk(mclk), .resetn(resetn),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(pi),
        .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .count_direction(dir), .module_irq_flag(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic results();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // a used-up wait counts as a mismatch and ends the run
    task automatic tmo(input int n);
        if (n >= 200)
        begin
            chk("bus wait", 32'h1, 32'h0);
            results();
        end
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n = 0;
        logic aw_ok = 1'h0;
        logic w_ok = 1'h0;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok) && n < 200)
        begin
            @(posedge mclk);
            n++;
            if (awready && !aw_ok)
            begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready && !w_ok)
            begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do
        begin
            @(posedge mclk);
            n++;
        end while (bvalid !== 1'h1 && n < 200);
        r = bresp;
        bready <= 1'h0;
        tmo(n);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
            if (arready && arvalid)
                arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        tmo(n);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hF, r);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, e);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (12) @(posedge mclk);
        resetn <= 1'h1;
        repeat (3) @(posedge mclk);
        // reset values, unmapped place, write and read back
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                wr(rows[i].addr, rows[i].data, rows[i].strb, r);
                chk("bresp", r, rows[i].resp);
            end
            rd(rows[i].addr, d, r);
            chk("rdata", d, rows[i].exp);
            chk("rresp", r, rows[i].resp);
        end
        // x4 counting, direction and error below zero
        wreg(`QD_OFF_CTRL, 32'h0600);
        wreg(`QD_OFF_POS, 32'h0);
        enc.step(1'h1, 4);
        rchk("pos x4 up", `QD_OFF_POS, 32'h4);
        chk("dir up", dir, 32'h1);
        rchk("ctrl dir", `QD_OFF_CTRL, 32'h0E00);
        enc.step(1'h0, 2);
        rchk("pos x4 down", `QD_OFF_POS, 32'h2);
        chk("dir down", dir, 32'h0);
        enc.step(1'h0, 4);
        rchk("pos past error", `QD_OFF_POS, 32'hFFFE);
        rchk("error flag", `QD_OFF_CTRL, 32'h8600);
        chk("flag on error", irq, 32'h1);
        wreg(`QD_OFF_STAT, 32'h1);
        wreg(`QD_OFF_CTRL, 32'h0600);
        rchk("error cleared", `QD_OFF_CTRL, 32'h0600);
        chk("flag cleared", irq, 32'h0);
        wreg(`QD_OFF_FILT, 32'h0100);
        wreg(`QD_OFF_POS, 32'h0);
        enc.step(1'h0, 1);
        rchk("masked error", `QD_OFF_CTRL, 32'h8600);
        chk("masked flag", irq, 32'h0);
        wreg(`QD_OFF_CTRL, 32'h0400);
        wreg(`QD_OFF_FILT, 32'h0);
        // x2 counting and max-count reset
        wreg(`QD_OFF_POS, 32'h10);
        enc.step(1'h1, 4);
        rchk("pos x2", `QD_OFF_POS, 32'h12);
        wreg(`QD_OFF_CTRL, 32'h0700);
        wreg(`QD_OFF_MAX, 32'h3);
        wreg(`QD_OFF_POS, 32'h2);
        enc.step(1'h1, 1);
        chk("no flag below max", irq, 32'h0);
        enc.step(1'h1, 1);
        rchk("max wrap up", `QD_OFF_POS, 32'h0);
        chk("flag max wrap", irq, 32'h1);
        enc.step(1'h0, 1);
        rchk("max wrap down", `QD_OFF_POS, 32'h3);
        wreg(`QD_OFF_MAX, 32'hFFFF);
        enc.align();
        // index qualification in x4 and x2
        foreach (irows[i])
        begin
            wreg(`QD_OFF_CTRL, irows[i].ctrl);
            wreg(`QD_OFF_FILT, irows[i].filt);
            wreg(`QD_OFF_POS, 32'h55);
            wreg(`QD_OFF_STAT, 32'h1);
            enc.pulse_index();
            rchk("pos index", `QD_OFF_POS, irows[i].clr ? 32'h0 : 32'h55);
            chk("flag index", irq, {31'h0, irows[i].flag});
        end
        // timer mode
        wreg(`QD_OFF_FILT, 32'h0);
        wreg(`QD_OFF_CTRL, 32'h0600);
        wreg(`QD_OFF_POS, 32'h20);
        wreg(`QD_OFF_MAX, 32'h22);
        wreg(`QD_OFF_STAT, 32'h1);
        wreg(`QD_OFF_CTRL, 32'h0900);
        rchk("pos kept", `QD_OFF_POS, 32'h20);
        enc.glitch_a(12);
        enc.glitch_a(12);
        rchk("timer up", `QD_OFF_POS, 32'h22);
        chk("no flag before", irq, 32'h0);
        enc.glitch_a(12);
        rchk("timer period", `QD_OFF_POS, 32'h0);
        chk("flag period", irq, 32'h1);
        wreg(`QD_OFF_CTRL, 32'h0100);
        enc.glitch_a(12);
        rchk("timer down", `QD_OFF_POS, 32'h22);
        wreg(`QD_OFF_CTRL, 32'h0901);
        enc.glitch_a(12);
        rchk("timer pin dir", `QD_OFF_POS, 32'h21);
        chk("dir pin", dir, 32'h0);
        // sleep and idle
        cpu_sleep <= 1'h1;
        enc.glitch_a(12);
        cpu_sleep <= 1'h0;
        rchk("sleep halt", `QD_OFF_POS, 32'h21);
        wreg(`QD_OFF_CTRL, 32'h2901);
        cpu_idle <= 1'h1;
        enc.glitch_a(12);
        rchk("idle halt", `QD_OFF_POS, 32'h21);
        wreg(`QD_OFF_CTRL, 32'h0901);
        enc.glitch_a(12);
        cpu_idle <= 1'h0;
        rchk("idle run", `QD_OFF_POS, 32'h20);
        // noise filter: short glitch rejected at slow ticks, passed at fast
        wreg(`QD_OFF_CTRL, 32'h0600);
        wreg(`QD_OFF_FILT, 32'h00B0);
        enc.hold = 40;
        enc.step(1'h0, 1);
        enc.glitch_a(10);
        rchk("pos filtered", `QD_OFF_POS, 32'h1F);
        chk("dir filtered", dir, 32'h0);
        wreg(`QD_OFF_FILT, 32'h0080);
        enc.glitch_a(10);
        chk("dir fast filter", dir, 32'h1);
        // mid-run reset: filters off, count and flags back to reset values
        resetn <= 1'h0;
        repeat (2) @(posedge mclk);
        resetn <= 1'h1;
        repeat (3) @(posedge mclk);
        rchk("filt after reset", `QD_OFF_FILT, 32'h0);
        rchk("pos after reset", `QD_OFF_POS, 32'h0);
        chk("flag after reset", irq, 32'h0);
        chk("dir after reset", dir, 32'h0);
        results();
    end
endmodule // testbench
`default_nettype wire
